// *** core/sut_consts.vh ***
// Constants for the single channel up timer.
`ifndef SUT_CONSTS_VH
`define SUT_CONSTS_VH
`define SUT_CNT_W 16
`define SUT_CNT_RST 16'h0000
`define SUT_PSC_RST 16'h0000
`define SUT_CAR_RST 16'hffff
`define SUT_OCM_KEEP 3'h0
`define SUT_OCM_SET 3'h1
`define SUT_OCM_CLR 3'h2
`define SUT_OCM_TOG 3'h3
`define SUT_OCM_FLO 3'h4
`define SUT_OCM_FHI 3'h5
`define SUT_OCM_PWM0 3'h6
`define SUT_OCM_PWM1 3'h7
`define SUT_MS_OUT 2'h0
`define SUT_FLT_W 4
`define SUT_ICP_W 2
`endif

// *** core/sut_timer.v ***
// Single channel 16-bit up timer with prescaler, capture, compare and PWM.
// What this block does
// - One internal clock, divided to counter tick when running.
// - Prescaler divides by stored value plus one.
// - New prescale takes effect at next update.
// - Counter counts zero to reload, then restarts.
// - Update event on every counter overflow.
// - Software update trigger clears counter, raises update.
// - Update inhibit suppresses updates, buffers keep values.
// - Update copies buffered reload and prescale to active.
// - Input synchronized, filtered, edge chosen by polarity.
// - Input divider merges several edges into one capture.
// - Capture latches counter, sets flag, gated interrupt.
// - Nonzero mode select means input; writes ignored.
// - Capture while flag set also sets over-capture.
// - Software channel trigger raises channel event.
// - Compare match sets channel flag, gated interrupt.
// - Match action keep, set, clear or toggle.
// - Modes four and five force inactive, active.
// - PWM modes use reload period, channel duty.
// - PWM0 value above reload gives always active.
// - PWM0 value zero gives always inactive.
// - Debug halt with hold bit stops counter.
// - Flags set by hardware, held until software clears.
// - Update source select limits update interrupt sources.
`include "sut_consts.vh"
module sut_timer #(
  parameter CNT_W = `SUT_CNT_W,
  parameter FLT_W = `SUT_FLT_W
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Control
  input wire counter_run,
  input wire update_inhibit,
  input wire update_source_select,
  input wire reload_shadow_enable,
  input wire debug_halted,
  input wire debug_hold,
  input wire software_update_trigger,
  input wire software_channel_trigger,
  // Buffered values and channel value write
  input wire [CNT_W-1:0] prescale_value,
  input wire [CNT_W-1:0] reload_value,
  input wire [CNT_W-1:0] channel_value_wdata,
  input wire channel_value_we,
  // Channel configuration
  input wire [1:0] channel_mode_select,
  input wire [FLT_W-1:0] capture_filter_setting,
  input wire [1:0] input_event_divider,
  input wire channel_polarity,
  input wire [2:0] compare_output_mode,
  input wire compare_shadow_enable,
  input wire channel_output_enable,
  // Interrupt enables and flag clears
  input wire update_interrupt_enable,
  input wire channel_interrupt_enable,
  input wire update_flag_clear,
  input wire channel_event_flag_clear,
  input wire over_capture_flag_clear,
  // Channel pins
  input wire channel_input,
  output wire channel_out_o,
  output wire channel_out_oe,
  // Status
  output wire [CNT_W-1:0] counter_value,
  output wire [CNT_W-1:0] channel_value,
  output wire update_flag,
  output wire channel_event_flag,
  output wire over_capture_flag,
  output wire output_reference_signal,
  output wire update_irq,
  output wire channel_irq
);

  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] psc_cnt_r;
  reg [CNT_W-1:0] psc_act_r;
  reg [CNT_W-1:0] car_act_r;
  reg [CNT_W-1:0] cv_act_r;
  reg [CNT_W-1:0] cv_buf_r;
  reg update_flag_r;
  reg chif_r;
  reg chof_r;
  reg oref_r;
  reg upd_irq_r;
  reg ch_irq_r;
  reg in_s1_r;
  reg in_s2_r;
  reg filt_r;
  reg filt_d_r;
  reg [FLT_W-1:0] flt_cnt_r;
  reg [1:0] icp_cnt_r;

  reg input_mode;
  reg [CNT_W-1:0] car_use;
  reg [CNT_W-1:0] cv_use;
  reg halted;
  reg run;
  reg tick;
  reg ovf;
  reg upd_evt;
  reg upd_irq_src;

  // Channel mode and the values that the counter compares against.
  always @* begin
    input_mode = (channel_mode_select != `SUT_MS_OUT);
    if (reload_shadow_enable) begin
      car_use = car_act_r;
    end else begin
      car_use = reload_value;
    end
    if (input_mode) begin
      cv_use = cv_buf_r;
    end else if (compare_shadow_enable) begin
      cv_use = cv_act_r;
    end else begin
      cv_use = cv_buf_r;
    end
  end

  // Counter tick: running, not held by debug, prescaler at terminal count.
  always @* begin
    halted = debug_halted & debug_hold;
    run = counter_run & ~halted;
    tick = run & (psc_cnt_r == psc_act_r);
    ovf = tick & (cnt_r == car_use);
    upd_evt = (ovf | software_update_trigger) & ~update_inhibit;
    // A trigger while the select bit is set still reloads, but stays out of the flag.
    if (update_source_select) begin
      upd_irq_src = ovf & ~update_inhibit;
    end else begin
      upd_irq_src = upd_evt;
    end
  end

  // Prescaler and counter.
  always @(posedge clk_sys) begin
    if (rst) begin
      psc_cnt_r <= `SUT_PSC_RST;
      cnt_r <= `SUT_CNT_RST;
    end else if (software_update_trigger) begin
      // The trigger restarts counting even when updates are inhibited.
      psc_cnt_r <= `SUT_PSC_RST;
      cnt_r <= `SUT_CNT_RST;
    end else if (run) begin
      if (tick) begin
        psc_cnt_r <= `SUT_PSC_RST;
        cnt_r <= ovf ? `SUT_CNT_RST : cnt_r + 1'b1;
      end else begin
        psc_cnt_r <= psc_cnt_r + 1'b1;
      end
    end
  end

  // Active copies of buffered values load only on an update event.
  always @(posedge clk_sys) begin
    if (rst) begin
      psc_act_r <= `SUT_PSC_RST;
      car_act_r <= `SUT_CAR_RST;
      cv_act_r <= `SUT_CNT_RST;
    end else if (upd_evt) begin
      psc_act_r <= prescale_value;
      car_act_r <= reload_value;
      cv_act_r <= cv_buf_r;
    end
  end

  // Input path: two-stage synchroniser, then a stability filter.
  always @(posedge clk_sys) begin
    if (rst) begin
      in_s1_r <= 1'b0;
      in_s2_r <= 1'b0;
      filt_r <= 1'b0;
      filt_d_r <= 1'b0;
      flt_cnt_r <= {FLT_W{1'b0}};
    end else begin
      in_s1_r <= channel_input;
      in_s2_r <= in_s1_r;
      filt_d_r <= filt_r;
      if (in_s2_r == filt_r) begin
        flt_cnt_r <= {FLT_W{1'b0}};
      end else if (flt_cnt_r >= capture_filter_setting) begin
        // The filter trades latency of setting plus one cycles for glitch immunity.
        filt_r <= in_s2_r;
        flt_cnt_r <= {FLT_W{1'b0}};
      end else begin
        flt_cnt_r <= flt_cnt_r + 1'b1;
      end
    end
  end

  reg edge_det;
  reg [1:0] icp_last;
  reg cap_evt;
  reg cmp_evt;
  reg ch_evt;

  // Edge choice, divider end point and the channel event sources.
  always @* begin
    if (channel_polarity) begin
      edge_det = filt_d_r & ~filt_r;
    end else begin
      edge_det = ~filt_d_r & filt_r;
    end
    case (input_event_divider)
      2'h0: icp_last = 2'h0;
      2'h1: icp_last = 2'h1;
      2'h2: icp_last = 2'h3;
      default: icp_last = 2'h3;
    endcase
    cap_evt = input_mode & edge_det & (icp_cnt_r == icp_last);
    cmp_evt = ~input_mode & (cnt_r == cv_use) & tick;
    ch_evt = cap_evt | cmp_evt | software_channel_trigger;
  end

  // Edge divider: divide by 1, 2 or 4 edges; the top code also counts four.
  always @(posedge clk_sys) begin
    if (rst) begin
      icp_cnt_r <= 2'h0;
    end else if (~input_mode) begin
      icp_cnt_r <= 2'h0;
    end else if (edge_det) begin
      icp_cnt_r <= (icp_cnt_r == icp_last) ? 2'h0 : icp_cnt_r + 1'b1;
    end
  end

  // Channel value: capture in input mode, software write in output mode.
  always @(posedge clk_sys) begin
    if (rst) begin
      cv_buf_r <= `SUT_CNT_RST;
    end else if (cap_evt) begin
      cv_buf_r <= cnt_r;
    end else if (channel_value_we & ~input_mode) begin
      cv_buf_r <= channel_value_wdata;
    end
  end

  reg update_flag_nxt;
  reg chif_nxt;
  reg chof_nxt;

  // Next flag values: a set in the same cycle as a clear wins.
  always @* begin
    if (upd_irq_src) begin
      update_flag_nxt = 1'b1;
    end else if (update_flag_clear) begin
      update_flag_nxt = 1'b0;
    end else begin
      update_flag_nxt = update_flag_r;
    end
    if (ch_evt) begin
      chif_nxt = 1'b1;
    end else if (channel_event_flag_clear) begin
      chif_nxt = 1'b0;
    end else begin
      chif_nxt = chif_r;
    end
    if (cap_evt & chif_r) begin
      chof_nxt = 1'b1;
    end else if (over_capture_flag_clear) begin
      chof_nxt = 1'b0;
    end else begin
      chof_nxt = chof_r;
    end
  end

  // Sticky flags and one-cycle interrupt pulses.
  always @(posedge clk_sys) begin
    if (rst) begin
      update_flag_r <= 1'b0;
      chif_r <= 1'b0;
      chof_r <= 1'b0;
      upd_irq_r <= 1'b0;
      ch_irq_r <= 1'b0;
    end else begin
      update_flag_r <= update_flag_nxt;
      chif_r <= chif_nxt;
      chof_r <= chof_nxt;
      upd_irq_r <= upd_irq_src & update_interrupt_enable;
      ch_irq_r <= ch_evt & channel_interrupt_enable;
    end
  end

  // Output reference generation.
  always @(posedge clk_sys) begin
    if (rst) begin
      oref_r <= 1'b0;
    end else if (~input_mode) begin
      case (compare_output_mode)
        `SUT_OCM_SET: begin
          if (cmp_evt) begin
            oref_r <= 1'b1;
          end
        end
        `SUT_OCM_CLR: begin
          if (cmp_evt) begin
            oref_r <= 1'b0;
          end
        end
        `SUT_OCM_TOG: begin
          if (cmp_evt) begin
            oref_r <= ~oref_r;
          end
        end
        `SUT_OCM_FLO: oref_r <= 1'b0;
        `SUT_OCM_FHI: oref_r <= 1'b1;
        // Value zero never matches below, value above reload always does.
        `SUT_OCM_PWM0: begin
          if (cnt_r < cv_use) begin
            oref_r <= 1'b1;
          end else begin
            oref_r <= 1'b0;
          end
        end
        `SUT_OCM_PWM1: begin
          if (cnt_r < cv_use) begin
            oref_r <= 1'b0;
          end else begin
            oref_r <= 1'b1;
          end
        end
        default: oref_r <= oref_r;
      endcase
    end
  end

  assign channel_out_o = oref_r ^ channel_polarity;
  assign channel_out_oe = channel_output_enable & ~input_mode;
  assign counter_value = cnt_r;
  assign channel_value = cv_buf_r;
  assign update_flag = update_flag_r;
  assign channel_event_flag = chif_r;
  assign over_capture_flag = chof_r;
  assign output_reference_signal = oref_r;
  assign update_irq = upd_irq_r;
  assign channel_irq = ch_irq_r;

endmodule // sut_timer

// *** test/sut_timer_sva.sv ***
// Port checks for the single channel up timer.
module sut_timer_sva #(parameter CNT_W = 16) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Controls
  input wire update_inhibit,
  input wire update_source_select,
  input wire software_update_trigger,
  input wire software_channel_trigger,
  input wire debug_halted,
  input wire debug_hold,
  input wire update_flag_clear,
  input wire channel_event_flag_clear,
  input wire channel_polarity,
  input wire [2:0] compare_output_mode,
  // Status
  input wire [CNT_W-1:0] counter_value,
  input wire update_flag,
  input wire channel_event_flag,
  input wire output_reference_signal,
  input wire channel_out_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence sw_upd; software_update_trigger && !update_inhibit && !update_source_select; endsequence
  sequence calm; $stable(output_reference_signal) && $stable(channel_polarity); endsequence
  upd_clear_a: assert property (software_update_trigger |=> counter_value == 0)
    else $error("counter not cleared");
  upd_flag_a: assert property (sw_upd |=> update_flag)
    else $error("update flag missing");
  debug_hold_a: assert property (debug_halted && debug_hold && !software_update_trigger |=> $stable(counter_value))
    else $error("counter moved");
  uflag_keep_a: assert property (update_flag && !update_flag_clear |=> update_flag)
    else $error("update flag lost");
  cflag_keep_a: assert property (channel_event_flag && !channel_event_flag_clear |=> channel_event_flag)
    else $error("channel flag lost");
  sw_chan_a: assert property (software_channel_trigger |=> channel_event_flag)
    else $error("channel flag missing");
  force_hi_a: assert property ((compare_output_mode == 3'h5) [*2] |-> output_reference_signal)
    else $error("force high failed");
  force_lo_a: assert property ((compare_output_mode == 3'h4) [*2] |-> !output_reference_signal)
    else $error("force low failed");
  pin_pol_a: assert property (calm [*2] |-> channel_out_o == (output_reference_signal ^ channel_polarity))
    else $error("pin level wrong");
endmodule // sut_timer_sva
bind sut_timer sut_timer_sva #(.CNT_W(CNT_W)) i_sut_timer_sva (.*);

// *** test/sut_pin_model.sv ***
// Far-side model: drives the capture input and resolves the output pin.
module sut_pin_model (
  // Clock and command
  input wire clk_sys,
  input wire pulse_go,
  // Pins
  input wire channel_out_o,
  input wire channel_out_oe,
  output logic channel_input,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  int left = 0;
  // Pulses last five cycles so that the filter setting the bench uses lets them through.
  always @(posedge clk_sys) begin
    left <= pulse_go ? 5 : (left > 0 ? left - 1 : 0);
  end
  assign channel_input = left > 0;
  // The pin has a pull-up, so it reads high while the timer does not drive it.
  assign pin_level = channel_out_oe ? channel_out_o : 1'b1;
endmodule // sut_pin_model

// *** test/sut_timer_tb.sv ***
// Self-checking bench for the single channel up timer.
module sut_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, pulse_go = 0, pin_level, channel_input, counter_run = 0, update_inhibit = 0;
  logic update_source_select = 0, reload_shadow_enable = 0, debug_halted = 0, debug_hold = 0;
  logic software_update_trigger = 0, software_channel_trigger = 0, channel_value_we = 0, channel_polarity = 0;
  logic [15:0] prescale_value = 0, reload_value = 2, channel_value_wdata = 0, counter_value, channel_value, c;
  logic [1:0] channel_mode_select = 0, input_event_divider = 0;
  logic [3:0] capture_filter_setting = 0;
  logic [2:0] compare_output_mode = 0;
  logic compare_shadow_enable = 0, channel_output_enable = 0, update_interrupt_enable = 1;
  logic channel_interrupt_enable = 1, update_flag_clear = 0, channel_event_flag_clear = 0, over_capture_flag_clear = 0;
  logic channel_out_o, channel_out_oe, update_flag, channel_event_flag, over_capture_flag, output_reference_signal;
  logic update_irq, channel_irq;
  int n_errors = 0, n_compared = 0;
  sut_timer i_sut_timer (.*);
  sut_pin_model i_sut_pin_model (.*);
  always #20 clk_sys = ~clk_sys;
  task cyc(int n); repeat (n) @(negedge clk_sys); endtask
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task clr; {update_flag_clear, channel_event_flag_clear, over_capture_flag_clear} = 3'h7; cyc(1); clr_off; endtask
  task clr_off; {update_flag_clear, channel_event_flag_clear, over_capture_flag_clear} = 3'h0; endtask
  task ug; software_update_trigger = 1; cyc(1); software_update_trigger = 0; endtask
  task wr(logic [15:0] v); channel_value_wdata = v; channel_value_we = 1; cyc(1); channel_value_we = 0; endtask
  task pulse; pulse_go = 1; cyc(1); pulse_go = 0; cyc(14); endtask
  task t_upd;
    counter_run = 1;
    ug;
    clr;
    for (int i = 1; i < 7; i++) begin
      chk("count", i % 3, counter_value);
      cyc(1);
    end
    chk("overflow flag", 1, update_flag);
    update_inhibit = 1;
    prescale_value = 1;
    clr;
    c = counter_value;
    cyc(3);
    chk("old factor", c, counter_value);
    chk("inhibited flag", 0, update_flag);
    ug;
    cyc(4);
    chk("inhibited load", 1, counter_value);
    update_inhibit = 0;
    ug;
    cyc(4);
    chk("new factor", 2, counter_value);
    // The counter stops first so that no real overflow meets the trigger.
    counter_run = 0;
    update_source_select = 1;
    clr;
    ug;
    chk("source select", 0, update_flag);
    update_source_select = 0;
    counter_run = 1;
  endtask
  task t_misc;
    {debug_halted, debug_hold} = 2'h3;
    c = counter_value;
    cyc(4);
    chk("debug hold", c, counter_value);
    {debug_halted, debug_hold} = 2'h0;
    clr;
    software_channel_trigger = 1;
    cyc(1);
    software_channel_trigger = 0;
    chk("channel trigger", 1, channel_event_flag);
  endtask
  task t_cap;
    counter_run = 0;
    channel_mode_select = 2'h1;
    capture_filter_setting = 4'h3;
    clr;
    c = channel_value;
    wr(16'hbeef);
    chk("write ignored", c, channel_value);
    pulse;
    chk("capture flag", 1, channel_event_flag);
    chk("capture value", counter_value, channel_value);
    pulse;
    chk("over capture", 1, over_capture_flag);
    channel_mode_select = 2'h0;
  endtask
  task t_pwm;
    counter_run = 1;
    channel_output_enable = 1;
    channel_polarity = 1;
    for (int k = 0; k < 4; k++) begin
      wr(k % 2 ? 16'h0005 : 16'h0000);
      compare_output_mode = k < 2 ? 3'h6 : 3'h2 + k;
      cyc(2);
      for (int i = 0; i < 8; i++) begin
        chk("reference", k % 2, output_reference_signal);
        chk("pin", 1 - k % 2, pin_level);
        cyc(1);
      end
    end
    wr(16'h0000);
    compare_output_mode = 3'h7;
    cyc(2);
    chk("pwm1 reference", 1, output_reference_signal);
    wr(16'h0001);
    compare_output_mode = 3'h2;
    cyc(8);
    chk("clear on match", 0, output_reference_signal);
    compare_output_mode = 3'h1;
    cyc(8);
    chk("set on match", 1, output_reference_signal);
    channel_output_enable = 0;
    cyc(2);
    chk("pin released", 1, pin_level);
  endtask
  task final_report;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    rst = 0;
    t_upd;
    t_misc;
    t_cap;
    t_pwm;
    final_report;
  end
  // The whole sequence needs some 134 cycles; this margin only catches a hang.
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    final_report;
  end
endmodule // sut_timer_tb
